// file: hdl/ext_irq_edge_polarity_ctrl.sv
// Interrupt control registers with edge-polarity selection for five external interrupt pins
//
// Summary of operation
// - Bit 4 of control word two picks interrupt 4 edge: 1 negative, 0 positive.
// - Bit 3 of control word two picks interrupt 3 edge: 1 negative, 0 positive.
// - Bits 13 to 5 of control word two read zero; writes there ignored.
// - Both control words reset to zero on every reset.
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
`include "ext_irq_regs.svh"

module ext_irq_edge_polarity_ctrl
    import ext_irq_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [`EXT_IRQ_NUM-1:0] ext_irq_pin,
    input wire logic [`TRAP_NUM-1:0] trap_event,
    input wire logic disable_instruction_active,
    output logic nesting_disable,
    output logic alternate_vector_table_select,
    output logic ext_irq0_edge_polarity,
    output logic ext_irq1_edge_polarity,
    output logic ext_irq2_edge_polarity,
    output logic ext_irq3_edge_polarity,
    output logic ext_irq4_edge_polarity,
    output logic [`EXT_IRQ_NUM-1:0] ext_irq_event,
    output logic irq
);

    // Address decode shared by read and write paths
    function automatic reg_sel_t decode_sel(input logic [31:0] addr);
        reg_sel_t sel;
        sel = SEL_NONE;
        if (addr[31:14] == 18'h00000 && addr[1:0] == 2'b00) begin
            case (addr[13:2])
                `IDX_CTRL_ONE: sel = SEL_CTRL_ONE;
                `IDX_CTRL_TWO: sel = SEL_CTRL_TWO;
                `IDX_STATUS: sel = SEL_STATUS;
                `IDX_MASK: sel = SEL_MASK;
                default: sel = SEL_NONE;
            endcase
        end
        return sel;
    endfunction

    // Register state
    logic nest_dis;
    logic [`FLAG_MSB:`FLAG_LSB] trap_flags;
    logic alt_vt;
    logic disable_instruction_active_q;
    logic [`EP_MSB:`EP_LSB] edge_pol;
    logic [`EXT_IRQ_NUM-1:0] status;
    logic [`EXT_IRQ_NUM-1:0] mask;

    // Reset images of both control words, picked apart per field below
    localparam logic [15:0] ctrl_one_rst = `CTRL_ONE_RST;
    localparam logic [15:0] ctrl_two_rst = `CTRL_TWO_RST;

    // Bus pipeline state
    logic wr_pend;
    reg_sel_t wr_sel;

    // Pin synchronisers and previous sampled level
    logic [`EXT_IRQ_NUM-1:0] pin_meta;
    logic [`EXT_IRQ_NUM-1:0] pin_sync;
    logic [`EXT_IRQ_NUM-1:0] pin_prev;

    // Address phase qualification
    wire addr_take = hsel & htrans[1] & hready;
    wire reg_sel_t cur_sel = decode_sel(haddr);
    wire rd_take = addr_take & ~hwrite;
    wire rd_status = rd_take & (cur_sel == SEL_STATUS);

    // Data phase write strobes
    wire wr_one = wr_pend & (wr_sel == SEL_CTRL_ONE);
    wire wr_two = wr_pend & (wr_sel == SEL_CTRL_TWO);
    wire wr_mask = wr_pend & (wr_sel == SEL_MASK);

    // Register images as software sees them
    wire [15:0] ctrl_one_img = {nest_dis, 10'h000, trap_flags, 1'b0};
    wire [15:0] ctrl_two_img = {alt_vt, disable_instruction_active_q, 9'h000, edge_pol};
    wire [31:0] rd_mux =
        (cur_sel == SEL_CTRL_ONE) ? {16'h0000, ctrl_one_img} :
        (cur_sel == SEL_CTRL_TWO) ? {16'h0000, ctrl_two_img} :
        (cur_sel == SEL_STATUS) ? {27'h0000000, status} :
        (cur_sel == SEL_MASK) ? {27'h0000000, mask} : 32'h00000000;

    // Per-pin edge detect steered by its polarity bit
    logic [`EXT_IRQ_NUM-1:0] pin_hit;
    genvar gi;
    generate
        for (gi = 0; gi < `EXT_IRQ_NUM; gi = gi + 1) begin : g_edge
            wire rise = pin_sync[gi] & ~pin_prev[gi];
            wire fall = ~pin_sync[gi] & pin_prev[gi];
            assign pin_hit[gi] = edge_pol[gi] ? fall : rise;
        end
    endgenerate

    // Sticky status: a read clears, a new edge in the same cycle wins
    wire [`EXT_IRQ_NUM-1:0] next_status = (rd_status ? 5'h00 : status) | pin_hit;
    wire next_irq = |(next_status & mask);

    // Trap flags: software may clear, a new trap wins
    wire [`FLAG_MSB:`FLAG_LSB] next_flags =
        (wr_one ? hwdata[`FLAG_MSB:`FLAG_LSB] : trap_flags) | trap_event;

    // Free-running synchroniser; the previous level tracks a high pin through reset, so no false edge
    always_ff @(posedge clk) begin
        pin_meta <= ext_irq_pin;
        pin_sync <= pin_meta;
        pin_prev <= pin_sync;
    end

    // Bus slave: zero wait states, always OKAY
    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend <= 1'b0;
            wr_sel <= SEL_NONE;
        end else begin
            wr_pend <= addr_take & hwrite;
            wr_sel <= cur_sel;
            if (rd_take) begin
                hrdata <= rd_mux;
            end
        end
    end

    // Control word one
    always_ff @(posedge clk) begin
        if (rst) begin
            nest_dis <= ctrl_one_rst[`NEST_DIS_BIT];
            trap_flags <= ctrl_one_rst[`FLAG_MSB:`FLAG_LSB];
        end else begin
            if (wr_one) begin
                nest_dis <= hwdata[`NEST_DIS_BIT];
            end
            trap_flags <= next_flags;
        end
    end

    // Control word two; bits 13 to 5 have no storage
    always_ff @(posedge clk) begin
        if (rst) begin
            alt_vt <= ctrl_two_rst[`ALT_VT_BIT];
            disable_instruction_active_q <= ctrl_two_rst[`DISABLE_INSTRUCTION_ACTIVE_BIT];
            edge_pol <= ctrl_two_rst[`EP_MSB:`EP_LSB];
        end else begin
            disable_instruction_active_q <= disable_instruction_active;
            if (wr_two) begin
                alt_vt <= hwdata[`ALT_VT_BIT];
                edge_pol <= hwdata[`EP_MSB:`EP_LSB];
            end
        end
    end

    // Status, mask and interrupt line
    always_ff @(posedge clk) begin
        if (rst) begin
            status <= `STATUS_RST;
            mask <= `MASK_RST;
            irq <= 1'b0;
            ext_irq_event <= 5'h00;
        end else begin
            status <= next_status;
            irq <= next_irq;
            ext_irq_event <= pin_hit;
            if (wr_mask) begin
                mask <= hwdata[`EXT_IRQ_NUM-1:0];
            end
        end
    end

    // Registered control outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            nesting_disable <= 1'b0;
            alternate_vector_table_select <= 1'b0;
            ext_irq0_edge_polarity <= 1'b0;
            ext_irq1_edge_polarity <= 1'b0;
            ext_irq2_edge_polarity <= 1'b0;
            ext_irq3_edge_polarity <= 1'b0;
            ext_irq4_edge_polarity <= 1'b0;
        end else begin
            nesting_disable <= nest_dis;
            alternate_vector_table_select <= alt_vt;
            ext_irq0_edge_polarity <= edge_pol[0];
            ext_irq1_edge_polarity <= edge_pol[1];
            ext_irq2_edge_polarity <= edge_pol[2];
            ext_irq3_edge_polarity <= edge_pol[3];
            ext_irq4_edge_polarity <= edge_pol[4];
        end
    end

    // Checks on edge selection, unimplemented bits and reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Pin falling edge with bit 4 set raises event 4 one cycle later
    AST_EP4_NEG: assert property (
        (edge_pol[4] && pin_prev[4] && !pin_sync[4]) |=> (ext_irq_event[4] && status[4]))
        else $error("Falling edge on pin 4 missed in negative mode");
    // Rising edge on pin 4 in negative mode is ignored
    AST_EP4_IGN: assert property (
        (edge_pol[4] && !pin_prev[4] && pin_sync[4]) |=> !ext_irq_event[4])
        else $error("Rising edge on pin 4 taken in negative mode");
    // Pin 3 rising edge with bit 3 clear
    AST_EP3_POS: assert property (
        (!edge_pol[3] && !pin_prev[3] && pin_sync[3]) |=> ext_irq_event[3])
        else $error("Rising edge on pin 3 missed in positive mode");
    // Pin 3 falling edge with bit 3 set
    AST_EP3_NEG: assert property (
        (edge_pol[3] && pin_prev[3] && !pin_sync[3]) |=> ext_irq_event[3])
        else $error("Falling edge on pin 3 missed in negative mode");
    // Read of control word two shows zero in bits 13 to 5
    AST_UNIMP_ZERO: assert property (
        (rd_take && cur_sel == SEL_CTRL_TWO) |=> (hrdata[13:5] == 9'h000))
        else $error("Unimplemented bits of control word two read nonzero");
    // Reset clears both control words
    AST_RESET_ZERO: assert property (disable iff (1'b0)
        rst |=> (ctrl_one_img == 16'h0000 && edge_pol == 5'h00 && !alt_vt))
        else $error("Control words not zero after reset");
    // Pin 0 falling edge in negative mode
    AST_EP0_NEG: assert property (
        (edge_pol[0] && pin_prev[0] && !pin_sync[0]) |=> ext_irq_event[0])
        else $error("Falling edge on pin 0 missed in negative mode");
    // Pin 2 event with its mask bit set raises the line at the next edge
    AST_IRQ_RAISE: assert property (
        (pin_hit[2] && mask[2] && !wr_mask) |=> irq)
        else $error("Unmasked event did not raise interrupt");
    // Pin 4 rising edge with bit 4 clear
    AST_EP4_POS: assert property (
        (!edge_pol[4] && !pin_prev[4] && pin_sync[4]) |=> (ext_irq_event[4] && status[4]))
        else $error("Rising edge on pin 4 missed in positive mode");
    // Rising edge on pin 3 in negative mode is ignored
    AST_EP3_IGN: assert property (
        (edge_pol[3] && !pin_prev[3] && pin_sync[3]) |=> !ext_irq_event[3])
        else $error("Rising edge on pin 3 taken in negative mode");
    // Pin 2 falling edge with bit 2 set
    AST_EP2_NEG: assert property (
        (edge_pol[2] && pin_prev[2] && !pin_sync[2]) |=> ext_irq_event[2])
        else $error("Falling edge on pin 2 missed in negative mode");
    // Falling edge on pin 2 in positive mode is ignored
    AST_EP2_IGN: assert property (
        (!edge_pol[2] && pin_prev[2] && !pin_sync[2]) |=> !ext_irq_event[2])
        else $error("Falling edge on pin 2 taken in positive mode");
    // Pin 1 falling edge with bit 1 set
    AST_EP1_NEG: assert property (
        (edge_pol[1] && pin_prev[1] && !pin_sync[1]) |=> ext_irq_event[1])
        else $error("Falling edge on pin 1 missed in negative mode");
    // Pin 1 rising edge with bit 1 clear
    AST_EP1_POS: assert property (
        (!edge_pol[1] && !pin_prev[1] && pin_sync[1]) |=> ext_irq_event[1])
        else $error("Rising edge on pin 1 missed in positive mode");
    // Pin 0 rising edge with bit 0 clear
    AST_EP0_POS: assert property (
        (!edge_pol[0] && !pin_prev[0] && pin_sync[0]) |=> ext_irq_event[0])
        else $error("Rising edge on pin 0 missed in positive mode");
    // Rising edge on pin 0 in negative mode is ignored
    AST_EP0_IGN: assert property (
        (edge_pol[0] && !pin_prev[0] && pin_sync[0]) |=> !ext_irq_event[0])
        else $error("Rising edge on pin 0 taken in negative mode");
    // A write to control word two stores bits 4 to 0 as written
    AST_POL_STORE: assert property (
        wr_two |=> (edge_pol == $past(hwdata[`EP_MSB:`EP_LSB])))
        else $error("Polarity bits not stored by a write");
    // Polarity outputs follow the stored bits one cycle behind
    AST_POL_OUT: assert property (
        1'b1 |=> ({ext_irq4_edge_polarity, ext_irq3_edge_polarity, ext_irq2_edge_polarity,
            ext_irq1_edge_polarity, ext_irq0_edge_polarity} == $past(edge_pol)))
        else $error("Polarity outputs do not follow control word two");

    // Status read, interrupt line and trap flag checks
    AST_READ_CLEAR: assert property (
        (rd_status && pin_hit == 5'h00) |=> (status == 5'h00))
        else $error("Status not cleared by its read");
    // Nothing pending and unmasked keeps the line low
    AST_IRQ_QUIET: assert property (
        ((status & mask) == 5'h00 && pin_hit == 5'h00) |=> !irq)
        else $error("Interrupt raised with nothing pending");
    // A trap pulse sets its flag even against a clearing write
    AST_FLAG_SET: assert property (
        (trap_event != 4'h0) |=> ((trap_flags & $past(trap_event)) == $past(trap_event)))
        else $error("Trap flag missed a trap pulse");

    // Main scenarios
    CVR_NEG_EDGE4: cover property (edge_pol[4] ##1 ext_irq_event[4]);
    CVR_READ_CLEAR: cover property (rd_status && status != 5'h00 ##1 status == 5'h00);
    CVR_IRQ: cover property (!irq ##1 irq);
    CVR_POS_EDGE3: cover property (!edge_pol[3] ##1 ext_irq_event[3]);
    CVR_TRAP_FLAG: cover property (trap_event != 4'h0 ##1 trap_flags != 4'h0);

endmodule

// file: hdl/ext_irq_pkg.sv
// Types shared by the interrupt control block
package ext_irq_pkg;

    // Register selected by a bus address
    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_CTRL_ONE,
        SEL_CTRL_TWO,
        SEL_STATUS,
        SEL_MASK
    } reg_sel_t;

endpackage

// file: hdl/ext_irq_regs.svh
// Register offsets, field positions, reset values and sizes of the interrupt control block
`ifndef EXT_IRQ_REGS_SVH
`define EXT_IRQ_REGS_SVH

// Number of external interrupt pins and trap flags
`define EXT_IRQ_NUM 5
`define TRAP_NUM 4

// Register indices; byte address is four times the index
`define IDX_CTRL_ONE 12'h080
`define IDX_CTRL_TWO 12'h082
`define IDX_STATUS 12'h084
`define IDX_MASK 12'h086

// Control word one fields
`define NEST_DIS_BIT 15
`define FLAG_LSB 1
`define FLAG_MSB 4

// Control word two fields
`define ALT_VT_BIT 15
`define DISABLE_INSTRUCTION_ACTIVE_BIT 14
`define EP_LSB 0
`define EP_MSB 4

// Reset values
`define CTRL_ONE_RST 16'h0000
`define CTRL_TWO_RST 16'h0000
`define STATUS_RST 5'h00
`define MASK_RST 5'h00

`endif

// file: verification/ext_irq_edge_polarity_ctrl_test.sv
// Self-checking bench for the interrupt control registers
`timescale 1ns/1ps
`include "ext_irq_regs.svh"
module ext_irq_edge_polarity_ctrl_test import ext_irq_pkg::*;;
    logic clk, rst, hsel, hwrite, dia, slow, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rd, d;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [4:0] lvl, pins;
    logic [3:0] trap;
    wire [4:0] pol, ev;
    wire nd, avs;
    int miscompares, checks, seed, p, s, i, e0;
    int evs = 0;
    localparam logic [31:0] A1 = 4 * `IDX_CTRL_ONE;
    localparam logic [31:0] A2 = 4 * `IDX_CTRL_TWO;
    localparam logic [31:0] AS = 4 * `IDX_STATUS;
    localparam logic [31:0] AM = 4 * `IDX_MASK;

    ext_pin_model u_pins (.clk(clk), .level(lvl), .slow(slow), .ext_irq_pin(pins));
    ext_irq_edge_polarity_ctrl u_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_irq_pin(pins),
        .trap_event(trap), .disable_instruction_active(dia), .nesting_disable(nd),
        .alternate_vector_table_select(avs), .ext_irq0_edge_polarity(pol[0]),
        .ext_irq1_edge_polarity(pol[1]), .ext_irq2_edge_polarity(pol[2]),
        .ext_irq3_edge_polarity(pol[3]), .ext_irq4_edge_polarity(pol[4]),
        .ext_irq_event(ev), .irq(irq));

    // Clock of 25 ns
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Count detected-edge pulses from the device
    always @(posedge clk) evs <= evs + $countones(ev);

    // Control word two as read back: only bits 15 and 4..0 store, bit 14 mirrors the level
    function automatic logic [31:0] exp_ctrl_two(logic [31:0] v, logic lv);
        return (v & 32'h0000801f) | {17'h0, lv, 14'h0};
    endfunction
    // Status after toggling one pin away from a steady level
    function automatic logic [31:0] exp_status(int pv, int sv, int iv);
        return (pv == sv) ? (32'h1 << iv) : 32'h0;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("miscompares=%0d checks=%0d", miscompares, checks);
        if (miscompares == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Wait for hready at a rising edge, bounded
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            miscompares++;
            results();
        end
    endtask

    // One single AHB-Lite word transfer
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] v, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= v;
        wait_ready();
        r = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask

    initial begin
        seed = 48874;
        {rst, hsel, haddr, htrans, hwrite, hwdata, dia, slow, lvl, trap} = '0;
        rst = 1'b1;
        hsize = 3'h2;
        miscompares = 0;
        checks = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        xfer(1'b0, A1, 32'h0, rd); chk(rd, 32'h0);
        xfer(1'b0, A2, 32'h0, rd); chk(rd, 32'h0);
        // Unmapped place ignores the write and reads zero
        xfer(1'b1, 32'h300, 32'hffffffff, rd);
        xfer(1'b0, 32'h300, 32'h0, rd); chk(rd, 32'h0);
        xfer(1'b1, A2, 32'hffff, rd);
        xfer(1'b0, A2, 32'h0, rd); chk(rd, 32'h801f);
        // Random control-two words and their polarity outputs
        repeat (40) begin
            d = $random(seed);
            dia <= d[20];
            xfer(1'b1, A2, d, rd);
            repeat (2) @(posedge clk);
            chk({27'h0, pol}, {27'h0, d[4:0]});
            chk({31'h0, avs}, {31'h0, d[15]});
            xfer(1'b0, A2, 32'h0, rd); chk(rd, exp_ctrl_two(d, d[20]));
        end
        // Control word one: nesting bit by a write, flags by a random trap pulse
        xfer(1'b1, A1, 32'h8000, rd);
        d = $random(seed);
        trap <= d[3:0];
        @(posedge clk);
        trap <= 4'h0;
        xfer(1'b0, A1, 32'h0, rd); chk(rd, {16'h0, 1'b1, 10'h0, d[3:0], 1'b0});
        chk({31'h0, nd}, 32'h1);
        // Reset in mid-run clears both words
        rst <= 1'b1;
        dia <= 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        xfer(1'b0, A1, 32'h0, rd); chk(rd, 32'h0);
        xfer(1'b0, A2, 32'h0, rd); chk(rd, 32'h0);
        // Every pin, both polarities, both edge directions; mask on only for negative polarity
        for (p = 0; p < 2; p++) for (s = 0; s < 2; s++) for (i = 0; i < 5; i++) begin
            lvl <= {5{s[0]}};
            d = $random(seed);
            slow <= d[0];
            xfer(1'b1, A2, {27'h0, {5{p[0]}}}, rd);
            xfer(1'b1, AM, p ? 32'h1f : 32'h0, rd);
            xfer(1'b0, AM, 32'h0, rd); chk(rd, p ? 32'h1f : 32'h0);
            repeat (8) @(posedge clk);
            xfer(1'b0, AS, 32'h0, rd);
            e0 = evs;
            lvl <= {5{s[0]}} ^ (5'h1 << i);
            repeat (8) @(posedge clk);
            chk({31'h0, irq}, {31'h0, p == 1 && exp_status(p, s, i) != 0});
            chk(evs - e0, {31'h0, exp_status(p, s, i) != 0});
            xfer(1'b0, AS, 32'h0, rd); chk(rd, exp_status(p, s, i));
            repeat (2) @(posedge clk);
            chk({31'h0, irq}, 32'h0);
        end
        results();
    end
endmodule

// file: verification/ext_pin_model.sv
// Model of the five external interrupt pins outside the device
`timescale 1ns/1ps
module ext_pin_model (
    input wire logic clk,
    input wire logic [4:0] level,
    input wire logic slow,
    output logic [4:0] ext_irq_pin
);
    logic [4:0] stage_one;
    logic [4:0] stage_two;
    // Pins start low so the device sees no edge out of reset
    initial begin
        stage_one = 5'h00;
        stage_two = 5'h00;
    end
    // Pins follow a request one cycle later, or two in slow mode
    always @(posedge clk) begin
        stage_one <= level;
        stage_two <= stage_one;
    end
    assign ext_irq_pin = slow ? stage_two : stage_one;
endmodule
